// ### ipcs_map.svh
`ifndef IPCS_MAP_SVH
`define IPCS_MAP_SVH
`define IPCS_ADDR_CTRL 12'h000
`define IPCS_ADDR_LOCAL_IP 12'h004
`define IPCS_ADDR_NETMASK 12'h008
`define IPCS_ADDR_GATEWAY 12'h00c
`define IPCS_ADDR_IDLE_LIMIT 12'h010
`define IPCS_ADDR_STATUS 12'h014
`define IPCS_ADDR_SEQ_ERRORS 12'h018
`define IPCS_ADDR_LOOKUP_FAILS 12'h01c
`define IPCS_CTRL_OPEN_BIT 0
`define IPCS_CTRL_HC_BIT 1
`define IPCS_IDLE_LIMIT_RESET 32'h0000ffff
`define IPCS_MTU_BYTES 16'd1500
`define IPCS_BCAST_IP 32'hffffffff
`define IPCS_BCAST_HANDLE 8'hff
`define IPCS_AR_RETRY_MS 32'd1000
`define IPCS_CLK_KHZ 32'd25000
`define IPCS_AR_RETRY_CYCLES (`IPCS_AR_RETRY_MS * `IPCS_CLK_KHZ)
`endif

// ### ipcs_pkg.sv
package ipcs_pkg;
  typedef enum logic [7:0] {
    IPCS_AR_REGISTER = 8'h00,
    IPCS_AR_REGISTER_ACK = 8'h01,
    IPCS_AR_UNREGISTER = 8'h02,
    IPCS_AR_UNREGISTER_ACK = 8'h03,
    IPCS_AR_LOOKUP = 8'h04,
    IPCS_AR_LOOKUP_REPLY = 8'h05,
    IPCS_AR_MCAST_REG = 8'h08,
    IPCS_AR_MCAST_ACK = 8'h09,
    IPCS_AR_MCAST_UNREG = 8'h0a,
    IPCS_AR_MCAST_UNREG_ACK = 8'h0b
  } ipcs_msg_e;
  typedef enum logic [5:0] {
    IPCS_ST_CLOSED = 6'b000001,
    IPCS_ST_BCAST = 6'b000010,
    IPCS_ST_IDLE = 6'b000100,
    IPCS_ST_LOOKUP = 6'b001000,
    IPCS_ST_OPEN = 6'b010000,
    IPCS_ST_REGISTER = 6'b100000
  } ipcs_state_e;
  typedef logic [7:0] ipcs_seq_t;
endpackage

// ### ipcs_prio_map.sv
module ipcs_prio_map
(
  input wire logic [2:0] precedence_i,
  output logic [1:0] prio_field_o,
  output logic signaling_class_o
);
  logic [2:0] mapped_prio;
  // Precedence pairs share one priority: 4, 3, 2, 1 for the four pairs.
  assign mapped_prio = 3'd4 - {1'b0, precedence_i[2:1]};
  // The header field carries priority minus one, 0 to 3.
  assign prio_field_o = 2'(mapped_prio - 3'd1);
  // Level 1 of the four levels is shared with MAC signaling.
  assign signaling_class_o = (mapped_prio == 3'd1);
endmodule

// ### ipcs_packet_path.sv
// Operation
// - Netmask of local address decides whether destination is in local subnetwork.
// - Off-subnet destinations search the table with the default gateway address.
// - Entries hold remote address, handle, activity time, scheme, receive and transmit sequence.
// - Idle connections may close; both ends then remove their entry.
// - Without connection, resolve MAC address, then open unicast IP connection.
// - Connection request carries local address and negotiates header compression.
// - Opening creates broadcast connection for broadcast sends and all broadcast receives.
// - Datagrams up to 1500 bytes accepted; segmentation layer handles larger.
// - Compressed connections keep independent 8-bit transmit and receive counters.
// - Transmit inserts current transmit sequence into header, then increments it.
// - Receive compares header sequence with expected; mismatch signals decompressor error.
// - Expected receive sequence always loads the received header value.
// - No compression on broadcast or multicast connections.
// - Precedence 0-1 gives 4, 2-3 gives 3, 4-5 gives 2, 6-7 gives 1.
// - Header priority field equals mapped priority minus one.
// - Highest of four levels also carries MAC signaling.
// - Message types above 11 are reserved and never generated.
// - Other message types are 0 to 5 and 8 to 11.
// - Lookup reply counts as success only with status zero.
// - Address-resolution request is retransmitted after one second without reply.
//
// The register offsets and the APB register port were chosen for this implementation.
`include "ipcs_map.svh"
module ipcs_packet_path
  import ipcs_pkg::*;
#(
  parameter int ENTRIES = 4,
  parameter logic [31:0] RETRY_CYCLES = `IPCS_AR_RETRY_CYCLES,
  parameter logic [47:0] LOCAL_MAC = 48'h0
)
(
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic TX_VALID_I,
  input wire logic [31:0] TX_DEST_IP_I,
  input wire logic [2:0] TX_PRECEDENCE_I,
  input wire logic [15:0] TX_LENGTH_I,
  output logic TX_READY_O,
  output logic TX_SEND_O,
  output logic [7:0] TX_HANDLE_O,
  output logic [1:0] TX_PRIO_FIELD_O,
  output logic TX_SIGNALING_CLASS_O,
  output logic TX_HAS_SEQ_O,
  output ipcs_pkg::ipcs_seq_t TX_SEQ_O,
  output logic TX_DROP_O,
  output logic AR_SEND_O,
  output logic [7:0] AR_BYTE_O,
  output logic AR_LAST_O,
  input wire logic AR_READY_I,
  input wire logic AR_REPLY_VALID_I,
  input wire ipcs_pkg::ipcs_msg_e AR_REPLY_TYPE_I,
  input wire logic [47:0] AR_REPLY_MAC_I,
  input wire logic [7:0] AR_REPLY_STATUS_I,
  output logic CONN_REQ_O,
  output logic [47:0] CONN_MAC_O,
  output logic [31:0] CONN_LOCAL_IP_O,
  output logic CONN_HC_O,
  output logic CONN_BCAST_O,
  input wire logic CONN_ACK_I,
  input wire logic [7:0] CONN_HANDLE_I,
  input wire logic CONN_HC_I,
  output logic CONN_CLOSE_O,
  output logic [7:0] CONN_CLOSE_HANDLE_O,
  input wire logic REMOTE_CLOSE_I,
  input wire logic [7:0] REMOTE_CLOSE_HANDLE_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_HANDLE_I,
  input wire ipcs_pkg::ipcs_seq_t RX_SEQ_I,
  output logic RX_UP_O,
  output logic RX_TYPE_ERROR_O
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl, local_ip, netmask, gateway, idle_limit, seq_errors, lookup_fails;
  logic [31:0] now;
  ipcs_state_e state;
  logic [31:0] pend_ip, retry_cnt;
  logic [3:0] ar_idx;
  logic ent_valid [ENTRIES];
  logic [31:0] conn_remote_ip [ENTRIES];
  logic [7:0] conn_mac_handle [ENTRIES];
  logic [31:0] conn_last_activity [ENTRIES];
  logic conn_compression_scheme [ENTRIES];
  ipcs_seq_t conn_rx_expected_seq [ENTRIES];
  ipcs_seq_t conn_tx_next_seq [ENTRIES];
  logic [ENTRIES-1:0] hit_vec, rx_vec, free_vec, idle_vec, rclose_vec;
  logic [$clog2(ENTRIES)-1:0] hit_idx, rx_idx, free_idx, idle_idx;
  logic [103:0] resolution_msg_type;
  logic [1:0] prio_field;
  logic signaling;

  wire apb_wr = PSEL_I && PENABLE_I && PWRITE_I;
  wire apb_rd_hit = (PADDR_I[11:5] == 7'h00);
  wire is_bcast = (TX_DEST_IP_I == `IPCS_BCAST_IP);
  wire is_mcast = (TX_DEST_IP_I[31:28] == 4'he);
  wire in_subnet = ((TX_DEST_IP_I & netmask) == (local_ip & netmask));
  wire [31:0] next_hop = in_subnet ? TX_DEST_IP_I : gateway;
  wire too_long = (TX_LENGTH_I > `IPCS_MTU_BYTES);
  wire tx_hit = |hit_vec;
  wire tx_fire = TX_VALID_I && TX_READY_O;
  wire ar_fire = AR_SEND_O && AR_READY_I;
  wire reply_ok = AR_REPLY_VALID_I && (AR_REPLY_TYPE_I == IPCS_AR_LOOKUP_REPLY) &&
                  (AR_REPLY_STATUS_I == 8'h00);
  wire reply_bad = AR_REPLY_VALID_I && (AR_REPLY_TYPE_I == IPCS_AR_LOOKUP_REPLY) &&
                   (AR_REPLY_STATUS_I != 8'h00);
  wire reg_ack = AR_REPLY_VALID_I && (AR_REPLY_TYPE_I == IPCS_AR_REGISTER_ACK);
  wire rx_on_bcast = RX_VALID_I && (RX_HANDLE_I == `IPCS_BCAST_HANDLE);
  wire rx_hit = RX_VALID_I && (|rx_vec);

  ////////////////////////////////////////////////////////////////////////////
  // Combinational searches over the connection table.
  generate
    for (genvar g = 0; g < ENTRIES; g++)
    begin : g_tab
      assign hit_vec[g] = ent_valid[g] && (conn_remote_ip[g] == next_hop);
      assign rx_vec[g] = ent_valid[g] && (conn_mac_handle[g] == RX_HANDLE_I);
      assign free_vec[g] = !ent_valid[g];
      assign idle_vec[g] = ent_valid[g] && ((now - conn_last_activity[g]) > idle_limit);
      assign rclose_vec[g] = REMOTE_CLOSE_I && ent_valid[g] && (conn_mac_handle[g] == REMOTE_CLOSE_HANDLE_I);
    end
  endgenerate

  always_comb
  begin
    hit_idx = '0;
    rx_idx = '0;
    free_idx = '0;
    idle_idx = '0;
    for (int i = ENTRIES - 1; i >= 0; i--)
    begin
      if (hit_vec[i])
        hit_idx = i[$clog2(ENTRIES)-1:0];
      if (rx_vec[i])
        rx_idx = i[$clog2(ENTRIES)-1:0];
      if (free_vec[i])
        free_idx = i[$clog2(ENTRIES)-1:0];
      if (idle_vec[i])
        idle_idx = i[$clog2(ENTRIES)-1:0];
    end
  end

  ipcs_prio_map u_prio
  (
    .precedence_i(TX_PRECEDENCE_I),
    .prio_field_o(prio_field),
    .signaling_class_o(signaling)
  );

  // Lookup is type and address; registration adds the MAC address, high byte first.
  assign resolution_msg_type = (state == IPCS_ST_REGISTER) ?
    {IPCS_AR_REGISTER, local_ip, LOCAL_MAC, 16'h0} :
    {IPCS_AR_LOOKUP, pend_ip, 64'h0};
  assign AR_BYTE_O = resolution_msg_type[103 - 8 * ar_idx -: 8];
  assign AR_SEND_O = ((state == IPCS_ST_LOOKUP) || (state == IPCS_ST_REGISTER)) && (retry_cnt == 32'h0);
  assign AR_LAST_O = (state == IPCS_ST_REGISTER) ? (ar_idx == 4'd10) : (ar_idx == 4'd4);
  assign TX_READY_O = (state == IPCS_ST_IDLE) && !CONN_REQ_O;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !apb_rd_hit;
  assign CONN_LOCAL_IP_O = local_ip;
  assign RX_UP_O = rx_on_bcast || rx_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      ctrl <= 32'h0;
      local_ip <= 32'h0;
      netmask <= 32'h0;
      gateway <= 32'h0;
      idle_limit <= `IPCS_IDLE_LIMIT_RESET;
    end
    else if (apb_wr)
    begin
      case (PADDR_I)
        `IPCS_ADDR_CTRL: ctrl <= PWDATA_I;
        `IPCS_ADDR_LOCAL_IP: local_ip <= PWDATA_I;
        `IPCS_ADDR_NETMASK: netmask <= PWDATA_I;
        `IPCS_ADDR_GATEWAY: gateway <= PWDATA_I;
        `IPCS_ADDR_IDLE_LIMIT: idle_limit <= PWDATA_I;
        default: ;
      endcase
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
      PRDATA_O <= 32'h0;
    else
    begin
      case (PADDR_I)
        `IPCS_ADDR_CTRL: PRDATA_O <= ctrl;
        `IPCS_ADDR_LOCAL_IP: PRDATA_O <= local_ip;
        `IPCS_ADDR_NETMASK: PRDATA_O <= netmask;
        `IPCS_ADDR_GATEWAY: PRDATA_O <= gateway;
        `IPCS_ADDR_IDLE_LIMIT: PRDATA_O <= idle_limit;
        `IPCS_ADDR_STATUS: PRDATA_O <= {20'h0, 4'(ENTRIES - $countones(free_vec)), 2'b0, state};
        `IPCS_ADDR_SEQ_ERRORS: PRDATA_O <= seq_errors;
        `IPCS_ADDR_LOOKUP_FAILS: PRDATA_O <= lookup_fails;
        default: PRDATA_O <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control sequence: broadcast setup, resolution, connection setup.
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      state <= IPCS_ST_CLOSED;
      pend_ip <= 32'h0;
      retry_cnt <= 32'h0;
      ar_idx <= 4'h0;
      CONN_REQ_O <= 1'b0;
      CONN_MAC_O <= 48'h0;
      CONN_HC_O <= 1'b0;
      CONN_BCAST_O <= 1'b0;
      lookup_fails <= 32'h0;
      now <= 32'h0;
    end
    else
    begin
      now <= now + 32'h1;
      if (ar_fire)
        ar_idx <= AR_LAST_O ? 4'h0 : ar_idx + 4'h1;
      if (ar_fire && AR_LAST_O)
        retry_cnt <= RETRY_CYCLES;
      else if (retry_cnt > 32'h1)
        retry_cnt <= retry_cnt - 32'h1;
      else if (retry_cnt == 32'h1)
        retry_cnt <= 32'h0;
      if (reply_bad)
        lookup_fails <= lookup_fails + 32'h1;
      case (state)
        IPCS_ST_CLOSED:
          if (ctrl[`IPCS_CTRL_OPEN_BIT])
          begin
            CONN_REQ_O <= 1'b1;
            CONN_BCAST_O <= 1'b1;
            CONN_HC_O <= 1'b0;
            state <= IPCS_ST_BCAST;
          end
        IPCS_ST_BCAST:
          if (CONN_ACK_I)
          begin
            CONN_REQ_O <= 1'b0;
            CONN_BCAST_O <= 1'b0;
            retry_cnt <= 32'h0;
            state <= IPCS_ST_REGISTER;
          end
        IPCS_ST_REGISTER:
          if (reg_ack)
          begin
            retry_cnt <= 32'h0;
            ar_idx <= 4'h0;
            state <= IPCS_ST_IDLE;
          end
        IPCS_ST_IDLE:
          if (tx_fire && !is_bcast && !is_mcast && !tx_hit && !too_long)
          begin
            pend_ip <= next_hop;
            retry_cnt <= 32'h0;
            ar_idx <= 4'h0;
            state <= IPCS_ST_LOOKUP;
          end
        IPCS_ST_LOOKUP:
          if (reply_ok)
          begin
            CONN_MAC_O <= AR_REPLY_MAC_I;
            CONN_HC_O <= ctrl[`IPCS_CTRL_HC_BIT];
            CONN_REQ_O <= 1'b1;
            retry_cnt <= 32'h0;
            state <= IPCS_ST_OPEN;
          end
        IPCS_ST_OPEN:
          if (CONN_ACK_I)
          begin
            CONN_REQ_O <= 1'b0;
            state <= IPCS_ST_IDLE;
          end
        default: state <= IPCS_ST_CLOSED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath outputs and connection table.
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      TX_SEND_O <= 1'b0;
      TX_HANDLE_O <= 8'h0;
      TX_PRIO_FIELD_O <= 2'h0;
      TX_SIGNALING_CLASS_O <= 1'b0;
      TX_HAS_SEQ_O <= 1'b0;
      TX_SEQ_O <= 8'h0;
      TX_DROP_O <= 1'b0;
      RX_TYPE_ERROR_O <= 1'b0;
      CONN_CLOSE_O <= 1'b0;
      CONN_CLOSE_HANDLE_O <= 8'h0;
      seq_errors <= 32'h0;
      for (int i = 0; i < ENTRIES; i++)
      begin
        ent_valid[i] <= 1'b0;
        conn_remote_ip[i] <= 32'h0;
        conn_mac_handle[i] <= 8'h0;
        conn_last_activity[i] <= 32'h0;
        conn_compression_scheme[i] <= 1'b0;
        conn_rx_expected_seq[i] <= 8'h0;
        conn_tx_next_seq[i] <= 8'h0;
      end
    end
    else
    begin
      TX_SEND_O <= tx_fire && !too_long && (is_bcast || is_mcast || tx_hit);
      TX_DROP_O <= tx_fire && (too_long || (!is_bcast && !is_mcast && !tx_hit));
      TX_PRIO_FIELD_O <= prio_field;
      TX_SIGNALING_CLASS_O <= signaling;
      TX_HANDLE_O <= (is_bcast || is_mcast) ? `IPCS_BCAST_HANDLE : conn_mac_handle[hit_idx];
      TX_HAS_SEQ_O <= !is_bcast && !is_mcast && conn_compression_scheme[hit_idx];
      TX_SEQ_O <= conn_tx_next_seq[hit_idx];
      RX_TYPE_ERROR_O <= rx_hit && conn_compression_scheme[rx_idx] && (RX_SEQ_I != conn_rx_expected_seq[rx_idx]);
      if (rx_hit && conn_compression_scheme[rx_idx] && (RX_SEQ_I != conn_rx_expected_seq[rx_idx]))
        seq_errors <= seq_errors + 32'h1;
      CONN_CLOSE_O <= |idle_vec;
      CONN_CLOSE_HANDLE_O <= conn_mac_handle[idle_idx];
      if (tx_fire && !too_long && !is_bcast && !is_mcast && tx_hit)
      begin
        conn_last_activity[hit_idx] <= now;
        if (conn_compression_scheme[hit_idx])
          conn_tx_next_seq[hit_idx] <= conn_tx_next_seq[hit_idx] + 8'h1;
      end
      if (rx_hit)
      begin
        conn_last_activity[rx_idx] <= now;
        if (conn_compression_scheme[rx_idx])
          conn_rx_expected_seq[rx_idx] <= RX_SEQ_I;
      end
      for (int i = 0; i < ENTRIES; i++)
        if (rclose_vec[i] || (idle_vec[i] && (i == int'(idle_idx))))
          ent_valid[i] <= 1'b0;
      if ((state == IPCS_ST_OPEN) && CONN_ACK_I && (|free_vec))
      begin
        ent_valid[free_idx] <= 1'b1;
        conn_remote_ip[free_idx] <= pend_ip;
        conn_mac_handle[free_idx] <= CONN_HANDLE_I;
        conn_last_activity[free_idx] <= now;
        conn_compression_scheme[free_idx] <= CONN_HC_I;
        conn_rx_expected_seq[free_idx] <= 8'h0;
        conn_tx_next_seq[free_idx] <= 8'h0;
      end
    end
  end
endmodule

// ### ipcs_packet_path_assertions.sv
module ipcs_packet_path_checker
(
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic TX_VALID_I,
  input wire logic [31:0] TX_DEST_IP_I,
  input wire logic [2:0] TX_PRECEDENCE_I,
  input wire logic [15:0] TX_LENGTH_I,
  input wire logic TX_READY_O,
  input wire logic TX_SEND_O,
  input wire logic TX_DROP_O,
  input wire logic [7:0] TX_HANDLE_O,
  input wire logic [1:0] TX_PRIO_FIELD_O,
  input wire logic TX_SIGNALING_CLASS_O,
  input wire logic TX_HAS_SEQ_O,
  input wire logic AR_SEND_O,
  input wire logic [7:0] AR_BYTE_O,
  input wire logic AR_LAST_O,
  input wire logic AR_READY_I,
  input wire logic CONN_REQ_O,
  input wire logic CONN_ACK_I,
  input wire logic CONN_BCAST_O,
  input wire logic CONN_HC_O,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_HANDLE_I,
  input wire logic RX_UP_O
);
  logic ar_first;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  ////////////////////////////////////////////////////////////////////////////////
  // Marks the byte that opens each address-resolution message.
  always_ff @(posedge MCLK_I)
    if (SYS_RST_I)
      ar_first <= 1'b1;
    else if (AR_SEND_O && AR_READY_I)
      ar_first <= AR_LAST_O;
  ////////////////////////////////////////////////////////////////////////////////
  a_tx_answers: assert property (TX_VALID_I && TX_READY_O |=> TX_SEND_O != TX_DROP_O)
    else $error("accepted datagram got no single answer");
  a_prio_field: assert property (TX_VALID_I && TX_READY_O ##1 TX_SEND_O |->
    TX_PRIO_FIELD_O == 2'd3 - $past(TX_PRECEDENCE_I[2:1])) else $error("priority field wrong");
  a_signal_class: assert property (TX_SEND_O |-> TX_SIGNALING_CLASS_O == (TX_PRIO_FIELD_O == 2'd0))
    else $error("signaling class flag wrong");
  a_bcast_plain: assert property (TX_VALID_I && TX_READY_O && TX_DEST_IP_I == 32'hffffffff ##1 TX_SEND_O |->
    TX_HANDLE_O == 8'hff && !TX_HAS_SEQ_O) else $error("broadcast datagram not on plain broadcast handle");
  a_mtu_drop: assert property (TX_VALID_I && TX_READY_O && TX_LENGTH_I > 16'd1500 |=> TX_DROP_O)
    else $error("oversize datagram not dropped");
  a_rx_bcast_up: assert property (RX_VALID_I && RX_HANDLE_I == 8'hff |-> RX_UP_O)
    else $error("broadcast packet not passed up");
  a_ar_type_known: assert property (AR_SEND_O && ar_first |-> AR_BYTE_O <= 8'd11 && !(AR_BYTE_O inside {8'd6, 8'd7}))
    else $error("reserved message type sent");
  a_ar_hold: assert property (AR_SEND_O && !AR_READY_I |=> AR_SEND_O && $stable(AR_BYTE_O) && $stable(AR_LAST_O))
    else $error("message byte changed while stalled");
  a_conn_hold: assert property (CONN_REQ_O && !CONN_ACK_I |=> CONN_REQ_O)
    else $error("connection request dropped before answer");
  a_bcast_no_hc: assert property (CONN_REQ_O && CONN_BCAST_O |-> !CONN_HC_O)
    else $error("compression offered on broadcast connection");
endmodule
bind ipcs_packet_path ipcs_packet_path_checker u_checker (.MCLK_I, .SYS_RST_I, .TX_VALID_I, .TX_DEST_IP_I,
  .TX_PRECEDENCE_I, .TX_LENGTH_I, .TX_READY_O, .TX_SEND_O, .TX_DROP_O, .TX_HANDLE_O, .TX_PRIO_FIELD_O,
  .TX_SIGNALING_CLASS_O, .TX_HAS_SEQ_O, .AR_SEND_O, .AR_BYTE_O, .AR_LAST_O, .AR_READY_I, .CONN_REQ_O,
  .CONN_ACK_I, .CONN_BCAST_O, .CONN_HC_O, .RX_VALID_I, .RX_HANDLE_I, .RX_UP_O);

// ### ipcs_mac_partner.sv
module ipcs_mac_partner
  import ipcs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic conn_req_i,
  input wire logic conn_bcast_i,
  input wire logic conn_hc_i,
  input wire logic ar_send_i,
  input wire logic [7:0] ar_byte_i,
  input wire logic ar_last_i,
  input wire logic [7:0] lookup_status_i,
  output logic conn_ack_o,
  output logic [7:0] conn_handle_o,
  output logic conn_hc_o,
  output logic ar_ready_o,
  output logic ar_reply_valid_o,
  output ipcs_pkg::ipcs_msg_e ar_reply_type_o,
  output logic [47:0] ar_reply_mac_o,
  output logic [7:0] ar_reply_status_o
);
  logic first;
  logic pend;
  logic [7:0] msg;
  logic [2:0] delay;
  logic [2:0] conn_wait;
  logic [7:0] next_handle;
  initial
  begin
    {conn_ack_o, conn_handle_o, conn_hc_o, ar_ready_o, ar_reply_valid_o, ar_reply_mac_o, ar_reply_status_o} = '0;
    ar_reply_type_o = IPCS_AR_REGISTER_ACK;
  end
  // Idle MAC, status and handle answer fields keep changing so that nothing stale can be mistaken for a reply.
  always @(posedge clk_i)
  begin
    conn_ack_o <= 1'b0;
    ar_reply_valid_o <= 1'b0;
    ar_ready_o <= $urandom_range(3) != 0;
    ar_reply_mac_o <= ~ar_reply_mac_o;
    ar_reply_status_o <= ~ar_reply_status_o;
    conn_handle_o <= ~conn_handle_o;
    if (rst_i)
    begin
      first <= 1'b1;
      pend <= 1'b0;
      conn_wait <= 3'd0;
      next_handle <= 8'h11;
    end
    else
    begin
      if (ar_send_i && ar_ready_o)
      begin
        if (first)
          msg <= ar_byte_i;
        first <= ar_last_i;
        pend <= ar_last_i;
        delay <= 3'd0;
      end
      else if (pend)
        delay <= delay + 3'd1;
      if (pend && delay == 3'd4)
      begin
        pend <= 1'b0;
        ar_reply_valid_o <= 1'b1;
        ar_reply_type_o <= (msg == 8'h00) ? IPCS_AR_REGISTER_ACK : IPCS_AR_LOOKUP_REPLY;
        ar_reply_status_o <= (msg == 8'h00) ? 8'h00 : lookup_status_i;
        ar_reply_mac_o <= {40'h0200000000, next_handle};
      end
      conn_wait <= (conn_req_i && !conn_ack_o) ? conn_wait + 3'd1 : 3'd0;
      if (conn_wait == 3'd3)
      begin
        conn_ack_o <= 1'b1;
        conn_handle_o <= conn_bcast_i ? 8'hff : next_handle;
        conn_hc_o <= conn_hc_i && !conn_bcast_i;
        if (!conn_bcast_i)
          next_handle <= next_handle + 8'h01;
        conn_wait <= 3'd0;
      end
    end
  end
endmodule

// ### tb_ipv4_convergence_packet_path.sv
`include "ipcs_map.svh"
module tb_ipv4_convergence_packet_path
  import ipcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK_I, SYS_RST_I, PSEL_I, PENABLE_I, PWRITE_I, PREADY_O, PSLVERR_O, TX_VALID_I, TX_READY_O, TX_SEND_O;
  logic TX_SIGNALING_CLASS_O, TX_HAS_SEQ_O, TX_DROP_O, AR_SEND_O, AR_LAST_O, AR_READY_I, AR_REPLY_VALID_I;
  logic CONN_REQ_O, CONN_HC_O, CONN_BCAST_O, CONN_ACK_I, CONN_HC_I, CONN_CLOSE_O, REMOTE_CLOSE_I;
  logic RX_VALID_I, RX_UP_O, RX_TYPE_ERROR_O, e, rx_seen;
  logic [11:0] PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, TX_DEST_IP_I, CONN_LOCAL_IP_O, q;
  logic [2:0] TX_PRECEDENCE_I, p;
  logic [15:0] TX_LENGTH_I;
  logic [7:0] TX_HANDLE_O, AR_BYTE_O, AR_REPLY_STATUS_I, CONN_HANDLE_I, CONN_CLOSE_HANDLE_O, lk_status;
  logic [7:0] REMOTE_CLOSE_HANDLE_I, RX_HANDLE_I;
  logic [1:0] TX_PRIO_FIELD_O;
  ipcs_seq_t TX_SEQ_O, RX_SEQ_I;
  ipcs_msg_e AR_REPLY_TYPE_I;
  logic [47:0] AR_REPLY_MAC_I, CONN_MAC_O;
  logic [20:0] tx_seen;
  logic [20:0] txq[$];
  logic [8:0] arq[$];
  logic rxq[$];
  int fails, comparisons, n, i;
  ipcs_packet_path #(.RETRY_CYCLES(32'd50)) DUT (.MCLK_I, .SYS_RST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
    .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .TX_VALID_I, .TX_DEST_IP_I, .TX_PRECEDENCE_I, .TX_LENGTH_I,
    .TX_READY_O, .TX_SEND_O, .TX_HANDLE_O, .TX_PRIO_FIELD_O, .TX_SIGNALING_CLASS_O, .TX_HAS_SEQ_O, .TX_SEQ_O,
    .TX_DROP_O, .AR_SEND_O, .AR_BYTE_O, .AR_LAST_O, .AR_READY_I, .AR_REPLY_VALID_I, .AR_REPLY_TYPE_I,
    .AR_REPLY_MAC_I, .AR_REPLY_STATUS_I, .CONN_REQ_O, .CONN_MAC_O, .CONN_LOCAL_IP_O, .CONN_HC_O, .CONN_BCAST_O,
    .CONN_ACK_I, .CONN_HANDLE_I, .CONN_HC_I, .CONN_CLOSE_O, .CONN_CLOSE_HANDLE_O, .REMOTE_CLOSE_I,
    .REMOTE_CLOSE_HANDLE_I, .RX_VALID_I, .RX_HANDLE_I, .RX_SEQ_I, .RX_UP_O, .RX_TYPE_ERROR_O);
  ipcs_mac_partner u_mac (.clk_i(MCLK_I), .rst_i(SYS_RST_I), .conn_req_i(CONN_REQ_O), .conn_bcast_i(CONN_BCAST_O),
    .conn_hc_i(CONN_HC_O), .ar_send_i(AR_SEND_O), .ar_byte_i(AR_BYTE_O), .ar_last_i(AR_LAST_O),
    .lookup_status_i(lk_status), .conn_ack_o(CONN_ACK_I), .conn_handle_o(CONN_HANDLE_I), .conn_hc_o(CONN_HC_I),
    .ar_ready_o(AR_READY_I), .ar_reply_valid_o(AR_REPLY_VALID_I), .ar_reply_type_o(AR_REPLY_TYPE_I),
    .ar_reply_mac_o(AR_REPLY_MAC_I), .ar_reply_status_o(AR_REPLY_STATUS_I));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [63:0] seen, input logic [63:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task complete_run();
    if (fails == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function logic [20:0] sent(input logic [7:0] h, input logic [2:0] pr, input logic hs, input logic [7:0] s);
    return {2'b01, h, 2'd3 - pr[2:1], hs, hs ? s : 8'h00};
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge MCLK_I);
    {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I} <= {2'b10, w, a, d};
    @(posedge MCLK_I);
    PENABLE_I <= 1'b1;
    do @(posedge MCLK_I); while (PREADY_O !== 1'b1);
    q = PRDATA_O;
    e = PSLVERR_O;
    {PSEL_I, PENABLE_I} <= 2'b00;
  endtask
  task tx(input logic [31:0] ip, input logic [2:0] pr, input logic [15:0] len, input logic [20:0] x);
    do @(posedge MCLK_I); while (TX_READY_O !== 1'b1);
    txq.push_back(x);
    {TX_VALID_I, TX_DEST_IP_I, TX_PRECEDENCE_I, TX_LENGTH_I} <= {1'b1, ip, pr, len};
    do @(posedge MCLK_I); while (TX_READY_O !== 1'b1);
    TX_VALID_I <= 1'b0;
  endtask
  task arx(input logic [7:0] t, input logic [31:0] ip, input logic last);
    arq.push_back({1'b0, t});
    for (int k = 0; k < 4; k++)
      arq.push_back({last && k == 3, ip[31 - 8 * k -: 8]});
  endtask
  task rx(input logic [7:0] h, input logic [7:0] s, input logic err);
    rxq.push_back(err);
    @(posedge MCLK_I);
    {RX_VALID_I, RX_HANDLE_I, RX_SEQ_I} <= {1'b1, h, s};
    @(posedge MCLK_I);
    check(RX_UP_O, 1'b1);
    RX_VALID_I <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  assign tx_seen = {TX_DROP_O, TX_SEND_O, TX_DROP_O ? 19'h0 :
    {TX_HANDLE_O, TX_PRIO_FIELD_O, TX_HAS_SEQ_O, TX_HAS_SEQ_O ? TX_SEQ_O : 8'h00}};
  always @(posedge MCLK_I)
  begin
    if (TX_SEND_O === 1'b1 || TX_DROP_O === 1'b1)
      check(tx_seen, txq.size() > 0 ? txq.pop_front() : 21'h1fffff);
    if (AR_SEND_O === 1'b1 && AR_READY_I && arq.size() > 0)
      check({AR_LAST_O, AR_BYTE_O}, arq.pop_front());
    if (rx_seen)
      check(RX_TYPE_ERROR_O, rxq.pop_front());
    rx_seen <= RX_VALID_I;
  end
  initial
  begin
    MCLK_I = 1'b0;
    forever #20 MCLK_I = ~MCLK_I;
  end
  initial
  begin
    repeat (40000) @(posedge MCLK_I);
    fails++;
    complete_run();
  end
  initial
  begin
    {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I, TX_VALID_I, TX_DEST_IP_I, TX_PRECEDENCE_I, TX_LENGTH_I} = '0;
    {REMOTE_CLOSE_I, REMOTE_CLOSE_HANDLE_I, RX_VALID_I, RX_HANDLE_I, RX_SEQ_I, lk_status, rx_seen} = '0;
    void'($urandom(39));
    SYS_RST_I = 1'b1;
    repeat (5) @(posedge MCLK_I);
    SYS_RST_I <= 1'b0;
    apb(0, `IPCS_ADDR_IDLE_LIMIT, 0);
    check(q, `IPCS_IDLE_LIMIT_RESET);
    apb(1, 12'h020, 32'h1);
    apb(0, 12'h020, 0);
    check({e, q}, {1'b1, 32'h0});
    apb(1, `IPCS_ADDR_LOCAL_IP, 32'hc0a80105);
    apb(1, `IPCS_ADDR_NETMASK, 32'hffffff00);
    apb(1, `IPCS_ADDR_GATEWAY, 32'hc0a80101);
    arx(8'h00, 32'hc0a80105, 1'b0);
    for (i = 0; i < 6; i++)
      arq.push_back({i == 5, 8'h00});
    apb(1, `IPCS_ADDR_CTRL, 32'h3);
    for (i = 0; i < 8; i++)
      tx(32'hffffffff, i[2:0], 16'd64, sent(8'hff, i[2:0], 1'b0, 8'h0));
    tx(32'he0000001, 3'd5, 16'd64, sent(8'hff, 3'd5, 1'b0, 8'h0));
    apb(0, `IPCS_ADDR_STATUS, 0);
    check(q[11:0], {6'h0, IPCS_ST_IDLE});
    check(CONN_LOCAL_IP_O, 32'hc0a80105);
    arx(8'h04, 32'hc0a80101, 1'b1);
    tx(32'h0a000001, 3'd0, 16'd100, 21'h100000);
    tx(32'h0a000001, 3'd2, 16'd1500, sent(8'h11, 3'd2, 1'b1, 8'h00));
    tx(32'h08080808, 3'd7, 16'd40, sent(8'h11, 3'd7, 1'b1, 8'h01));
    tx(32'h0a000001, 3'd1, 16'd1501, 21'h100000);
    for (i = 2; i < 258; i++)
    begin
      p = 3'($urandom_range(7));
      tx(32'h08080808, p, 16'($urandom_range(1500, 20)), sent(8'h11, p, 1'b1, i[7:0]));
    end
    lk_status <= 8'h01;
    arx(8'h04, 32'hc0a80109, 1'b1);
    arx(8'h04, 32'hc0a80109, 1'b1);
    tx(32'hc0a80109, 3'd3, 16'd60, 21'h100000);
    @(posedge MCLK_I iff AR_REPLY_VALID_I === 1'b1);
    lk_status <= 8'h00;
    tx(32'hc0a80109, 3'd4, 16'd60, sent(8'h12, 3'd4, 1'b1, 8'h00));
    apb(0, `IPCS_ADDR_LOOKUP_FAILS, 0);
    check(q, 32'h1);
    rx(8'h11, 8'h00, 1'b0);
    rx(8'h11, 8'h07, 1'b1);
    rx(8'h11, 8'h07, 1'b0);
    rx(8'h11, 8'h08, 1'b1);
    rx(8'hff, 8'h33, 1'b0);
    apb(0, `IPCS_ADDR_SEQ_ERRORS, 0);
    check(q, 32'h2);
    @(posedge MCLK_I);
    {REMOTE_CLOSE_I, REMOTE_CLOSE_HANDLE_I} <= {1'b1, 8'h11};
    @(posedge MCLK_I);
    REMOTE_CLOSE_I <= 1'b0;
    arx(8'h04, 32'hc0a80101, 1'b1);
    tx(32'h0a000001, 3'd0, 16'd100, 21'h100000);
    tx(32'h0a000001, 3'd6, 16'd100, sent(8'h13, 3'd6, 1'b1, 8'h00));
    apb(1, `IPCS_ADDR_IDLE_LIMIT, 32'd20);
    for (n = 0; n < 400 && CONN_CLOSE_O !== 1'b1; n++)
      @(posedge MCLK_I);
    check(CONN_CLOSE_O, 1'b1);
    check(CONN_CLOSE_HANDLE_O, 8'h12);
    repeat (20) @(posedge MCLK_I);
    check(txq.size() + arq.size() + rxq.size(), 0);
    complete_run();
  end
endmodule
